// [logic/adfe_front_end.sv]
// audio converter front end: registers, fifos, interpolator, modulator
`timescale 1ns/100ps
// Operation
// - each channel has its own four-entry input fifo
// - empty fifo at sample time makes the default sample used instead
// - interpolator up-samples the stream by 256
// - interpolator drives modulator, whose bit stream leaves for the filter
// - control bit 8 picks signed when set, unsigned when clear
// - unsigned codes: FFFF top, 8000 midpoint, 0000 minimum
// - signed codes: 7FFF top, 0000 midpoint, 8000 minimum
// - converter clock comes from auxiliary clock via integer divider
// - 7-bit divider divides by field plus one, reset divides by six
// - one sample per channel consumed every 256 converter clocks
// - status bits 15 and 7 enable each channel's outputs
// - interrupt type bits pick empty or not-full condition
// - read-only full and empty flags show each fifo's state
// - left and right ports push 16-bit samples into their fifos
// - modulator is a second-order digital design
module adfe_front_end
  import adfe_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int WIDTH = SAMPLE_WIDTH
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              auxClkEn,
  input  wire logic              cpuIdle,
  input  wire logic [2:0]        regAddr,
  input  wire logic [15:0]       regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [15:0]       regRdData,
  output adfe_chan_out_type      leftOut,
  output adfe_chan_out_type      rightOut,
  output logic                   ampKeepOn,
  output logic                   leftIrq,
  output logic                   rightIrq,
  output logic                   sampleStrobe
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH != 4 || WIDTH != 16) begin
      $error("adfe_front_end: only 4 deep, 16 bit samples supported");
    end
  end

  logic [15:0] converterControl;
  logic [15:0] statusWritable;
  logic [15:0] defaultSample;
  logic [6:0]  divCount;
  logic [7:0]  osrCount;
  logic [15:0] statusRead;
  adfe_state_type state;
  adfe_state_type next_state;

  // register decode
  wire selControl = regAddr == OFS_CONTROL;
  wire selStatus  = regAddr == OFS_STATUS;
  wire selDefault = regAddr == OFS_DEFAULT;
  wire selLeft    = regAddr == OFS_LEFT;
  wire selRight   = regAddr == OFS_RIGHT;

  wire moduleEnable = converterControl[CTL_ENABLE_BIT];
  wire stopInIdle   = converterControl[CTL_SIDL_BIT];
  wire signMode     = converterControl[CTL_SIGN_MODE_SELECT_BIT];
  wire [6:0] divField = converterControl[CTL_DIV_LSB +: CTL_DIV_WIDTH];

  assign ampKeepOn = converterControl[CTL_AMPLIFIER_KEEP_ON_BIT_BIT];

  // divider: counts auxiliary clock enables, wraps at field value
  wire divWrap = auxClkEn && (divCount == divField);
  wire running = state == ST_RUN;
  wire convTick = running && divWrap;
  wire sampleTick = convTick && (osrCount == 8'hFF);

  // halt keeps the counters, so the sample grid resumes where it stopped
  wire haltRequest = stopInIdle && cpuIdle;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (moduleEnable) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!moduleEnable) begin
          next_state = ST_IDLE;
        end else if (haltRequest) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (!moduleEnable) begin
          next_state = ST_IDLE;
        end else if (!haltRequest) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || state == ST_IDLE) begin
      divCount <= 7'h00;
    end else if (running && auxClkEn) begin
      divCount <= divWrap ? 7'h00 : divCount + 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || state == ST_IDLE) begin
      osrCount <= 8'h00;
    end else if (convTick) begin
      osrCount <= osrCount + 8'h01;
    end
  end

  assign sampleStrobe = sampleTick;

  // register writes; masks keep read-only and unused bits at zero
  wire wrControl = regWrite && selControl;
  wire wrStatus  = regWrite && selStatus;
  wire wrDefault = regWrite && selDefault;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      converterControl <= CTL_RESET;
      statusWritable   <= ST_RESET;
      defaultSample    <= DEFAULT_RESET;
    end else begin
      if (wrControl) converterControl <= regWrData & CTL_WRITE_MASK;
      if (wrStatus)  statusWritable   <= regWrData & ST_WRITE_MASK;
      if (wrDefault) defaultSample    <= regWrData;
    end
  end

  // per-channel fifo, interpolator and modulator
  logic [1:0]  chFull;
  logic [1:0]  chEmpty;
  logic [1:0]  chBit;
  logic [15:0] chLast [2];
  wire  [1:0]  chPush = {regWrite && selRight, regWrite && selLeft};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      logic [WIDTH-1:0] mem [DEPTH];
      logic [PW-1:0]    wrPtr;
      logic [PW-1:0]    rdPtr;
      logic [PW:0]      count;
      logic [WIDTH-1:0] held;
      logic signed [17:0] curr;
      logic signed [17:0] prev;
      logic signed [25:0] interp;
      logic signed [31:0] acc1;
      logic signed [31:0] acc2;
      logic             outBit;

      wire full  = count == DEPTH[PW:0];
      wire empty = count == '0;
      wire doPush = chPush[ch] && !full;
      wire doPop  = sampleTick && !empty;
      // pick fifo head, or default sample when drained
      wire [WIDTH-1:0] chosen = empty ? defaultSample : mem[rdPtr];
      // unsigned maps to signed by flipping the top bit
      wire [WIDTH-1:0] asSigned =
        signMode ? chosen : {~chosen[WIDTH-1], chosen[WIDTH-2:0]};
      wire signed [17:0] nextCurr =
        18'(signed'(asSigned));

      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          wrPtr <= '0;
          rdPtr <= '0;
          count <= '0;
        end else begin
          if (doPush) begin
            mem[wrPtr] <= regWrData;
            wrPtr <= wrPtr + 1'b1;
          end
          if (doPop) rdPtr <= rdPtr + 1'b1;
          count <= count + (doPush ? 1'b1 : 1'b0) - (doPop ? 1'b1 : 1'b0);
        end
      end

      // linear interpolation: ramp from prev to curr over 256 ticks
      wire signed [25:0] step = 26'(curr - prev);
      always_ff @(posedge ref_clk) begin
        if (!reset_n || state == ST_IDLE) begin
          curr   <= '0;
          prev   <= '0;
          interp <= '0;
          held   <= '0;
        end else if (convTick) begin
          if (sampleTick) begin
            prev   <= curr;
            curr   <= nextCurr;
            held   <= chosen;
            interp <= 26'(curr) <<< 8;
          end else begin
            interp <= interp + step;
          end
        end
      end

      // second-order error feedback loop, one-bit quantiser
      localparam logic signed [31:0] FULLSCALE = 32'sh0200_0000;
      wire signed [31:0] fb = outBit ? FULLSCALE : -FULLSCALE;
      wire signed [31:0] nextAcc1 = acc1 + 32'(interp) - fb;
      wire signed [31:0] nextAcc2 = acc2 + nextAcc1 - fb;
      always_ff @(posedge ref_clk) begin
        if (!reset_n || state == ST_IDLE) begin
          acc1   <= '0;
          acc2   <= '0;
          outBit <= 1'b0;
        end else if (convTick) begin
          acc1   <= nextAcc1;
          acc2   <= nextAcc2;
          outBit <= !nextAcc2[31];
        end
      end

      assign chFull[ch]  = full;
      assign chEmpty[ch] = empty;
      assign chBit[ch]   = outBit;
      assign chLast[ch]  = held;
    end
  endgenerate

  // output enables fall with the datapath so a stopped channel never drives its bit outputs; midpoint enables are not gated by it
  wire leftDrive  = statusWritable[ST_LEFT_OUTPUT_ENABLE_BIT] && running;
  wire rightDrive = statusWritable[ST_RIGHT_OUTPUT_ENABLE_BIT] && running;
  wire leftMid    = statusWritable[ST_LEFT_MIDPOINT_OUTPUT_ENABLE_BIT];
  wire rightMid   = statusWritable[ST_RIGHT_MIDPOINT_OUTPUT_ENABLE_BIT];

  // outputs: modulator bit stream toward the reconstruction filter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      leftOut  <= '0;
      rightOut <= '0;
    end else begin
      leftOut.bitPos  <= chBit[0];
      leftOut.bitNeg  <= ~chBit[0];
      leftOut.enPos   <= leftDrive;
      leftOut.enNeg   <= leftDrive;
      leftOut.enMid   <= leftMid;
      rightOut.bitPos <= chBit[1];
      rightOut.bitNeg <= ~chBit[1];
      rightOut.enPos  <= rightDrive;
      rightOut.enNeg  <= rightDrive;
      rightOut.enMid  <= rightMid;
    end
  end

  // interrupt condition levels, for an external controller
  assign leftIrq  = statusWritable[ST_LEFT_INTERRUPT_CONDITION_BIT] ? chEmpty[0]
                                                  : !chFull[0];
  assign rightIrq = statusWritable[ST_RIGHT_INTERRUPT_CONDITION_BIT] ? chEmpty[1]
                                                  : !chFull[1];

  always_comb begin
    statusRead = statusWritable;
    statusRead[ST_LEFT_FIFO_FULL_FLAG_BIT]  = chFull[0];
    statusRead[ST_LEFT_FIFO_EMPTY_FLAG_BIT] = chEmpty[0];
    statusRead[ST_RIGHT_FIFO_FULL_FLAG_BIT]  = chFull[1];
    statusRead[ST_RIGHT_FIFO_EMPTY_FLAG_BIT] = chEmpty[1];
  end

  // read data valid only the cycle after the strobe; data ports read
  // back the sample last taken by that channel
  wire [15:0] readMux =
    selControl ? converterControl :
    selStatus  ? statusRead :
    selDefault ? defaultSample :
    selLeft    ? chLast[0] :
    selRight   ? chLast[1] : 16'h0000;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= regRead ? readMux : 16'h0000;
    end
  end
endmodule

// [common/adfe_pkg.sv]
// package of constants and types for the audio converter front end
package adfe_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_STATUS  = 3'h1;
  localparam logic [2:0] OFS_DEFAULT = 3'h2;
  localparam logic [2:0] OFS_LEFT    = 3'h3;
  localparam logic [2:0] OFS_RIGHT   = 3'h4;
  // control fields
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_SIDL_BIT   = 13;
  localparam int CTL_AMPLIFIER_KEEP_ON_BIT_BIT  = 12;
  localparam int CTL_SIGN_MODE_SELECT_BIT   = 8;
  localparam int CTL_DIV_LSB    = 0;
  localparam int CTL_DIV_WIDTH  = 7;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hB17F;
  localparam logic [15:0] CTL_RESET      = 16'h0005;
  // status fields
  localparam int ST_LEFT_OUTPUT_ENABLE_BIT   = 15;
  localparam int ST_LEFT_MIDPOINT_OUTPUT_ENABLE_BIT = 13;
  localparam int ST_LEFT_INTERRUPT_CONDITION_BIT = 10;
  localparam int ST_LEFT_FIFO_FULL_FLAG_BIT  = 9;
  localparam int ST_LEFT_FIFO_EMPTY_FLAG_BIT = 8;
  localparam int ST_RIGHT_OUTPUT_ENABLE_BIT   = 7;
  localparam int ST_RIGHT_MIDPOINT_OUTPUT_ENABLE_BIT = 5;
  localparam int ST_RIGHT_INTERRUPT_CONDITION_BIT = 2;
  localparam int ST_RIGHT_FIFO_FULL_FLAG_BIT  = 1;
  localparam int ST_RIGHT_FIFO_EMPTY_FLAG_BIT = 0;
  localparam logic [15:0] ST_WRITE_MASK = 16'hA4A4;
  localparam logic [15:0] ST_RESET      = 16'h0000;
  localparam logic [15:0] DEFAULT_RESET = 16'h0000;
  // datapath constants
  localparam int FIFO_DEPTH    = 4;
  localparam int OSR           = 256;
  localparam int SAMPLE_WIDTH  = 16;
  // one channel's converter outputs
  typedef struct packed {
    logic bitPos;
    logic bitNeg;
    logic enPos;
    logic enNeg;
    logic enMid;
  } adfe_chan_out_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_HALT
  } adfe_state_type;
endpackage

// [sim/adfe_checker.sv]
// assertions on the ports of the audio converter front end
`timescale 1ns/100ps
module adfe_checker
  import adfe_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              cpuIdle,
  input wire logic [2:0]        regAddr,
  input wire logic [15:0]       regWrData,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [15:0]       regRdData,
  input wire adfe_chan_out_type leftOut,
  input wire logic              sampleStrobe
);
  logic [15:0] ctl;
  logic [15:0] st;
  logic [15:0] dflt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // shadows of the writable bits, so readback needs no design internals
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctl  <= CTL_RESET;
      st   <= 16'h0000;
      dflt <= 16'h0000;
    end else if (regWrite) begin
      if (regAddr == OFS_CONTROL) ctl <= regWrData & CTL_WRITE_MASK;
      if (regAddr == OFS_STATUS) st <= regWrData & ST_WRITE_MASK;
      if (regAddr == OFS_DEFAULT) dflt <= regWrData;
    end
  end
  rd_idle_zero_a: assert property (
    !$past(regRead) |-> regRdData == 16'h0000)
    else $error("read data not zero outside a read");
  ctl_readback_a: assert property (
    $past(regRead) && $past(regAddr) == OFS_CONTROL
      |-> regRdData == $past(ctl))
    else $error("control readback differs");
  dflt_readback_a: assert property (
    $past(regRead) && $past(regAddr) == OFS_DEFAULT
      |-> regRdData == $past(dflt))
    else $error("default sample readback differs");
  strobe_pulse_a: assert property (
    $rose(sampleStrobe) |=> !sampleStrobe [*8])
    else $error("sample strobes too close");
  chan_off_a: assert property (
    !st[15] && !$past(st[15]) |-> !leftOut.enPos && !leftOut.enNeg)
    else $error("left outputs driven while disabled");
  en_off_a: assert property (
    !ctl[15] && !$past(ctl[15]) && !$past(ctl[15], 2)
      |-> !sampleStrobe && !leftOut.enPos)
    else $error("datapath active while module disabled");
  idle_halt_a: assert property (
    ctl[13] && $past(ctl[13], 2) && cpuIdle && $past(cpuIdle)
      && $past(cpuIdle, 2) |-> !sampleStrobe)
    else $error("sample consumed while halted in idle");
  neg_inv_a: assert property (
    leftOut.enPos |-> leftOut.bitNeg == !leftOut.bitPos)
    else $error("negative bit is not the inverse");
endmodule
bind adfe_front_end adfe_checker chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .cpuIdle(cpuIdle),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .leftOut(leftOut),
  .sampleStrobe(sampleStrobe)
);

// [sim/adfe_aux_osc.sv]
// auxiliary oscillator model giving one-cycle ticks
`timescale 1ns/100ps
module adfe_aux_osc #(
  parameter int PERIOD = 2
) (
  input  wire logic ref_clk,
  output logic      auxClkEn
);
  int cnt = 0;
  initial auxClkEn = 1'b0;
  // free running: the oscillator does not stop for resets
  always @(posedge ref_clk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    auxClkEn <= (cnt == PERIOD - 1);
  end
endmodule

// [sim/adfe_front_end_tb.sv]
// self-checking testbench for the audio converter front end
`timescale 1ns/100ps
module adfe_front_end_tb;
  import adfe_pkg::*;
  localparam int AUXP = 2;
  // aux tick 62.5 MHz / 3 keeps converter clock and sample rate legal
  localparam logic [6:0] DIV = 7'h02;
  localparam int GAP = OSR * (DIV + 1) * AUXP;
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              cpuIdle = 1'b0;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic              rdPend = 1'b0;
  logic [2:0]        regAddr = 3'h0;
  logic [15:0]       regWrData = 16'h0000;
  logic [15:0]       regRdData, v, dflt;
  logic [15:0]       smp [4];
  logic [15:0]       expq [$];
  logic              auxClkEn, ampKeepOn, leftIrq, rightIrq, sampleStrobe;
  adfe_chan_out_type leftOut, rightOut;
  int                errors = 0;
  int                comparisons = 0;
  int                n;
  always #4 ref_clk = ~ref_clk;
  adfe_aux_osc #(.PERIOD(AUXP)) osc (.ref_clk(ref_clk), .auxClkEn(auxClkEn));
  adfe_front_end dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .auxClkEn(auxClkEn), .cpuIdle(cpuIdle), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .leftOut(leftOut), .rightOut(rightOut),
    .ampKeepOn(ampKeepOn), .leftIrq(leftIrq), .rightIrq(rightIrq),
    .sampleStrobe(sampleStrobe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // strobes are not lowered here, so back-to-back calls drive each once
  task automatic bus(input logic w, input logic r, input logic [2:0] a,
                     input logic [15:0] d);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWrData <= d;
    if (r) expq.push_back(d);
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (rdPend) check(regRdData, expq.pop_front());
    rdPend <= regRead;
  end
  task automatic waitStrobe(output int cnt);
    cnt = 0;
    do begin
      @(negedge ref_clk);
      cnt++;
    end while (sampleStrobe !== 1'b1 && cnt < 3 * GAP);
    if (sampleStrobe !== 1'b1) errors++;
    @(posedge ref_clk);
  endtask
  task automatic countStrobes(output int hits);
    hits = 0;
    repeat (GAP + 100) begin
      @(negedge ref_clk);
      if (sampleStrobe === 1'b1) hits++;
    end
    @(posedge ref_clk);
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(40 * GAP * 8);
    errors++;
    results();
  end
  initial begin
    n = $urandom(94922);
    foreach (smp[i]) smp[i] = 16'($urandom);
    dflt = 16'($urandom);
    v = 16'($urandom) & 16'h7FFF;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    bus(0, 1, OFS_CONTROL, CTL_RESET);
    bus(0, 1, OFS_STATUS, 16'h0101);
    for (int a = 5; a < 8; a++) bus(0, 1, 3'(a), 16'h0000);
    bus(1, 0, OFS_CONTROL, v);
    bus(0, 1, OFS_CONTROL, v & CTL_WRITE_MASK);
    bus(1, 0, OFS_DEFAULT, dflt);
    bus(1, 0, OFS_LEFT, smp[0]);
    bus(1, 0, OFS_STATUS, 16'h0400);
    bus(0, 0, 3'h0, 16'h0000);
    check({15'h0, leftIrq}, 16'h0000);
    bus(1, 0, OFS_STATUS, 16'h0000);
    bus(0, 0, 3'h0, 16'h0000);
    check({15'h0, leftIrq}, 16'h0001);
    check({15'h0, rightIrq}, 16'h0001);
    for (int i = 1; i < 4; i++) bus(1, 0, OFS_LEFT, smp[i]);
    bus(1, 0, OFS_LEFT, ~smp[0]);
    bus(0, 1, OFS_STATUS, 16'h0201);
    bus(1, 0, OFS_CONTROL, {9'h102, DIV});
    bus(1, 0, OFS_STATUS, 16'h8000);
    bus(0, 0, 3'h0, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      waitStrobe(n);
      if (i > 0) check(16'(n + 3), 16'(GAP));
      bus(0, 1, OFS_LEFT, (i < 4) ? smp[i] : dflt);
      bus(0, 1, OFS_RIGHT, dflt);
      bus(0, 0, 3'h0, 16'h0000);
    end
    check({15'h0, leftOut.enPos}, 16'h0001);
    check({15'h0, rightOut.enPos}, 16'h0000);
    bus(0, 1, OFS_STATUS, 16'h8101);
    cpuIdle <= 1'b1;
    bus(1, 0, OFS_CONTROL, {9'h142, DIV});
    countStrobes(n);
    check(16'(n), 16'h0000);
    cpuIdle <= 1'b0;
    waitStrobe(n);
    bus(1, 0, OFS_CONTROL, {9'h000, DIV});
    countStrobes(n);
    check(16'(n), 16'h0000);
    check({15'h0, leftOut.enPos}, 16'h0000);
    results();
  end
endmodule
